// *** sbpm_top.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// System manager: bus arbitration, clock gating, power modes,
// power-on straps and PLL control registers over AXI4-Lite
module sbpm_top #(
	parameter int          STABLE_CYCLES = sbpm_pkg::OSC_STABLE_CYCLES,
	parameter logic [5:0]  CHIP_VERSION  = 6'h01,        // Arbitrary value
	parameter logic [23:0] PART_CODE     = 24'ha5_5a01    // Arbitrary value
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// AXI4-Lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read address
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// AXI4-Lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Bus masters
	input  wire logic [8:0]  bus_req,
	output logic      [8:0]  bus_grant,
	output logic             bus_busy,
	// Interrupt controller, same clock
	input  wire logic        irq_req,
	input  wire logic        fiq_req,
	input  wire logic        irq_unmasked_pending,
	// Wake pins
	input  wire logic [3:0]  ext_irq_n,
	input  wire logic        keypad_wake,
	input  wire logic        usb_device_wake,
	// Straps
	input  wire logic        strap_clock_source,
	input  wire logic        strap_endian,
	input  wire logic [1:0]  strap_boot_width,
	input  wire logic [1:0]  strap_package,
	// Clock enables
	output logic             core_clk_en,
	output logic             cache_clk_en,
	output logic             mem_clk_en,
	output logic             sys_clk_en,
	output logic             osc_en,
	output logic [31:0]      periph_clk_en,
	// Strap results
	output logic             sys_clk_from_pll,
	output logic             little_endian,
	output logic [1:0]       boot_width,
	// PLL controls
	output logic             pll_power_down,
	output logic [9:0]       pll_feedback_value,
	output logic [5:0]       pll_input_value,
	output logic [2:0]       pll_output_value
);
	// ============================================================
	// Register state
	logic [31:0] arb_reg, arb_next;           // arbitration_control
	logic [31:0] pll_reg, pll_next;           // system_pll_control
	logic [31:0] gate_reg, gate_next;         // clock_source_and_gating
	logic [31:0] pll2_reg, pll2_next;         // second_pll_control
	logic [31:0] aud_reg, aud_next;           // audio_pll_clock_control
	logic [31:0] wctl_reg, wctl_next;         // irq_wake_control
	logic [31:0] wflg_reg, wflg_next;         // irq_wake_flags
	logic [31:0] pm_reg, pm_next;             // power_mode_control
	logic [31:0] usb_reg, usb_next;           // usb_transceiver_control
	logic [5:0]  strap_reg, strap_next;       // Captured straps
	logic        strap_done_reg, strap_done_next;
	sbpm_pkg::sbpm_pwr_type pwr_reg, pwr_next; // Power state
	logic [31:0] warm_cnt_reg, warm_cnt_next; // Stabilise counter
	// Bus slave state
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	// Synchronised pins
	logic [3:0]  ext_irq_n_s;
	logic        keypad_s;
	logic        usb_s;
	logic [5:0]  strap_s;
	// Misc
	logic        wr_fire;
	logic        rd_fire;
	logic        boost_live;
	logic [3:0]  ext_hit;
	logic        wake_hit;

	// ============================================================
	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = data[8*b +: 8];
		return res & mask;
	endfunction

	// ============================================================
	// Output divider code to divide ratio
	function automatic logic [2:0] out_div(input logic [1:0] code);
		case (code)
			2'h0:    return 3'h1;
			2'h1:    return 3'h2;
			2'h2:    return 3'h2;
			default: return 3'h4;
		endcase
	endfunction

	// ============================================================
	// Pin synchronisers, wake pins and straps in one chain
	sbpm_sync #(
		.WIDTH (12)
	) u_sync (
		.aclk     (aclk),
		.async_in ({ext_irq_n, keypad_wake, usb_device_wake, strap_package,
			strap_boot_width, strap_endian, strap_clock_source}),
		.sync_out ({ext_irq_n_s, keypad_s, usb_s, strap_s})
	);

	// ============================================================
	// Arbiter; boost only counts in fixed mode with enable set
	assign boost_live = !arb_reg[sbpm_pkg::ARB_MODE_BIT] && arb_reg[sbpm_pkg::ARB_BOOST_EN_BIT]
		&& arb_reg[sbpm_pkg::ARB_BOOST_ACT_BIT];

	sbpm_arbiter #(
		.N    (sbpm_pkg::NUM_MASTERS),
		.CORE (sbpm_pkg::CORE_MASTER)
	) u_arb (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.rotate_mode (arb_reg[sbpm_pkg::ARB_MODE_BIT]),
		.core_boost  (boost_live),
		.bus_req     (bus_req),
		.bus_grant   (bus_grant),
		.bus_busy    (bus_busy)
	);

	// ============================================================
	// Wake detection: polarity bit 1 means high level wakes
	assign ext_hit  = ~(ext_irq_n_s ^ wctl_reg[7:4]) & wctl_reg[3:0];
	assign wake_hit = (|ext_hit) || keypad_s || usb_s;

	// ============================================================
	// Bus handshakes: write takes address and data together
	assign wr_fire = awvalid && wvalid && !bvalid_reg;
	assign rd_fire = arvalid && !rvalid_reg;
	assign awready = wr_fire;
	assign wready  = wr_fire;
	assign arready = !rvalid_reg;

	// ============================================================
	// Next state of registers, power machine and bus slave
	always_comb
	begin
		logic [31:0] rd;
		rd = '0;
		arb_next        = arb_reg;
		pll_next        = pll_reg;
		gate_next       = gate_reg;
		pll2_next       = pll2_reg;
		aud_next        = aud_reg;
		wctl_next       = wctl_reg;
		wflg_next       = wflg_reg;
		pm_next         = pm_reg;
		usb_next        = usb_reg;
		strap_next      = strap_reg;
		strap_done_next = 1'b1;
		pwr_next        = pwr_reg;
		warm_cnt_next   = warm_cnt_reg;
		bvalid_next     = bvalid_reg && !bready;
		bresp_next      = bresp_reg;
		rvalid_next     = rvalid_reg && !rready;
		rresp_next      = rresp_reg;
		rdata_next      = rdata_reg;

		// Straps caught once, first cycle after reset release
		if (!strap_done_reg)
		begin
			strap_next = strap_s;
			gate_next[sbpm_pkg::CLK_SRC_BIT] = strap_s[0];
		end

		// Register writes
		if (wr_fire)
		begin
			bvalid_next = 1'b1;
			bresp_next  = sbpm_pkg::RESP_OKAY;
			case (awaddr)
				sbpm_pkg::ADDR_PRODUCT_ID: ; // Read only, write ignored
				sbpm_pkg::ADDR_ARB_CTRL:
				begin
					arb_next = merge(arb_reg, wdata, wstrb, sbpm_pkg::MASK_ARB_CTRL)
						| (arb_reg & ~sbpm_pkg::MASK_ARB_CTRL);
					// Zero clears boost active, one does nothing
					if (wstrb[0] && !wdata[sbpm_pkg::ARB_BOOST_ACT_BIT])
						arb_next[sbpm_pkg::ARB_BOOST_ACT_BIT] = 1'b0;
				end
				sbpm_pkg::ADDR_SYS_PLL:    pll_next  = merge(pll_reg, wdata, wstrb, sbpm_pkg::MASK_SYS_PLL);
				sbpm_pkg::ADDR_CLK_GATE:   gate_next = merge(gate_reg, wdata, wstrb, sbpm_pkg::MASK_CLK_GATE);
				sbpm_pkg::ADDR_SECOND_PLL: pll2_next = merge(pll2_reg, wdata, wstrb, sbpm_pkg::MASK_SECOND_PLL);
				sbpm_pkg::ADDR_AUDIO_CLK:  aud_next  = merge(aud_reg, wdata, wstrb, sbpm_pkg::MASK_AUDIO_CLK);
				sbpm_pkg::ADDR_WAKE_CTRL:  wctl_next = merge(wctl_reg, wdata, wstrb, sbpm_pkg::MASK_WAKE_CTRL);
				sbpm_pkg::ADDR_WAKE_FLAGS:
					// Writing zero to a flag clears it
					if (wstrb[0])
						wflg_next = wflg_reg & {28'h000_0000, wdata[3:0]};
				sbpm_pkg::ADDR_POWER_MODE: pm_next   = merge(pm_reg, wdata, wstrb, sbpm_pkg::MASK_POWER_MODE);
				sbpm_pkg::ADDR_USB_XCVR:   usb_next  = merge(usb_reg, wdata, wstrb, 32'hffff_ffff);
				default: bresp_next = sbpm_pkg::RESP_DECERR;
			endcase
		end

		// Boost active set by a pending interrupt; set beats clear
		if (!arb_reg[sbpm_pkg::ARB_MODE_BIT] && arb_reg[sbpm_pkg::ARB_BOOST_EN_BIT] && irq_unmasked_pending)
			arb_next[sbpm_pkg::ARB_BOOST_ACT_BIT] = 1'b1;

		// Power state machine
		case (pwr_reg)
			sbpm_pkg::PWR_RUN:
				if (pm_reg[sbpm_pkg::PM_DEEP_BIT])
					pwr_next = sbpm_pkg::PWR_DOWN;
				else if (pm_reg[sbpm_pkg::PM_IDLE_BIT])
					pwr_next = sbpm_pkg::PWR_IDLE;
			sbpm_pkg::PWR_IDLE:
				// Any normal or fast interrupt restores the core
				if (irq_req || fiq_req)
				begin
					pwr_next = sbpm_pkg::PWR_RUN;
					pm_next[sbpm_pkg::PM_IDLE_BIT] = 1'b0;
				end
			sbpm_pkg::PWR_DOWN:
				if (wake_hit)
				begin
					pwr_next      = sbpm_pkg::PWR_WARM;
					warm_cnt_next = '0;
				end
			sbpm_pkg::PWR_WARM:
				// Oscillator running, clocks still gated
				if (warm_cnt_reg >= 32'(STABLE_CYCLES - 1))
				begin
					pwr_next = sbpm_pkg::PWR_RUN;
					pm_next[sbpm_pkg::PM_DEEP_BIT] = 1'b0;
				end
				else
					warm_cnt_next = warm_cnt_reg + 32'h0000_0001;
			default: pwr_next = sbpm_pkg::PWR_RUN;
		endcase

		// Wake flags record which ext_irq_n pin ended the sleep; set wins
		if (pwr_reg == sbpm_pkg::PWR_DOWN)
			wflg_next[3:0] = wflg_next[3:0] | ext_hit;

		// Register reads
		if (rd_fire)
		begin
			rvalid_next = 1'b1;
			rresp_next  = sbpm_pkg::RESP_OKAY;
			case (araddr)
				sbpm_pkg::ADDR_PRODUCT_ID:
					rd = {strap_reg[5:4], CHIP_VERSION, PART_CODE};
				sbpm_pkg::ADDR_ARB_CTRL:   rd = arb_reg;
				sbpm_pkg::ADDR_SYS_PLL:    rd = pll_reg;
				sbpm_pkg::ADDR_CLK_GATE:   rd = gate_reg;
				sbpm_pkg::ADDR_SECOND_PLL: rd = pll2_reg;
				sbpm_pkg::ADDR_AUDIO_CLK:  rd = aud_reg;
				sbpm_pkg::ADDR_WAKE_CTRL:  rd = wctl_reg;
				sbpm_pkg::ADDR_WAKE_FLAGS: rd = wflg_reg;
				sbpm_pkg::ADDR_POWER_MODE: rd = pm_reg;
				sbpm_pkg::ADDR_USB_XCVR:   rd = usb_reg;
				default:                   rresp_next = sbpm_pkg::RESP_DECERR;
			endcase
			rdata_next = rd;
		end
	end

	// ============================================================
	// Registers, synchronous active-low reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arb_reg        <= sbpm_pkg::RST_ARB_CTRL;
			pll_reg        <= sbpm_pkg::RST_SYS_PLL;
			gate_reg       <= sbpm_pkg::RST_CLK_GATE;
			pll2_reg       <= sbpm_pkg::RST_SECOND_PLL;
			aud_reg        <= sbpm_pkg::RST_ZERO;
			wctl_reg       <= sbpm_pkg::RST_ZERO;
			wflg_reg       <= sbpm_pkg::RST_ZERO;
			pm_reg         <= sbpm_pkg::RST_ZERO;
			usb_reg        <= sbpm_pkg::RST_ZERO;
			strap_reg      <= '0;
			strap_done_reg <= 1'b0;
			pwr_reg        <= sbpm_pkg::PWR_RUN;
			warm_cnt_reg   <= '0;
			bvalid_reg     <= 1'b0;
			bresp_reg      <= sbpm_pkg::RESP_OKAY;
			rvalid_reg     <= 1'b0;
			rresp_reg      <= sbpm_pkg::RESP_OKAY;
			rdata_reg      <= '0;
		end
		else
		begin
			arb_reg        <= arb_next;
			pll_reg        <= pll_next;
			gate_reg       <= gate_next;
			pll2_reg       <= pll2_next;
			aud_reg        <= aud_next;
			wctl_reg       <= wctl_next;
			wflg_reg       <= wflg_next;
			pm_reg         <= pm_next;
			usb_reg        <= usb_next;
			strap_reg      <= strap_next;
			strap_done_reg <= strap_done_next;
			pwr_reg        <= pwr_next;
			warm_cnt_reg   <= warm_cnt_next;
			bvalid_reg     <= bvalid_next;
			bresp_reg      <= bresp_next;
			rvalid_reg     <= rvalid_next;
			rresp_reg      <= rresp_next;
			rdata_reg      <= rdata_next;
		end
	end

	// ============================================================
	// Bus answers
	assign bvalid = bvalid_reg;
	assign bresp  = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rresp  = rresp_reg;
	assign rdata  = rdata_reg;

	// ============================================================
	// Clock enables; sleeping states drop what they must
	assign sys_clk_en    = (pwr_reg == sbpm_pkg::PWR_RUN) || (pwr_reg == sbpm_pkg::PWR_IDLE);
	assign osc_en        = (pwr_reg != sbpm_pkg::PWR_DOWN);
	assign core_clk_en   = (pwr_reg == sbpm_pkg::PWR_RUN);
	assign cache_clk_en  = (pwr_reg == sbpm_pkg::PWR_RUN);
	// Memory stays clocked in idle unless memory sleep also set
	assign mem_clk_en    = sys_clk_en && !((pwr_reg == sbpm_pkg::PWR_IDLE)
		&& pm_reg[sbpm_pkg::PM_MEM_BIT]);
	assign periph_clk_en = sys_clk_en ? (gate_reg & sbpm_pkg::MASK_CLK_GATE) : '0;

	// ============================================================
	// Strap and PLL outputs
	assign sys_clk_from_pll   = gate_reg[sbpm_pkg::CLK_SRC_BIT];
	assign little_endian      = strap_reg[1];
	assign boot_width         = strap_reg[3:2];
	assign pll_power_down     = pll_reg[sbpm_pkg::PLL_PWDN_BIT] || !osc_en;
	assign pll_feedback_value = {1'b0, pll_reg[sbpm_pkg::PLL_FB_MSB:sbpm_pkg::PLL_FB_LSB]}
		+ sbpm_pkg::PLL_DIV_OFFSET;
	assign pll_input_value    = {1'b0, pll_reg[sbpm_pkg::PLL_IN_MSB:sbpm_pkg::PLL_IN_LSB]}
		+ sbpm_pkg::PLL_DIV_OFFSET[5:0];
	assign pll_output_value   = out_div(pll_reg[sbpm_pkg::PLL_OD_MSB:sbpm_pkg::PLL_OD_LSB]);
endmodule // sbpm_top
`default_nettype wire

// *** sbpm_pkg.sv ***
`default_nettype none
// ============================================================
// Shared constants for the system bus arbiter and power manager
package sbpm_pkg;
	// ============================================================
	// Register byte addresses
	localparam logic [31:0] ADDR_PRODUCT_ID   = 32'hfff0_0000;
	localparam logic [31:0] ADDR_ARB_CTRL     = 32'hfff0_0004;
	localparam logic [31:0] ADDR_SYS_PLL      = 32'hfff0_0008;
	localparam logic [31:0] ADDR_CLK_GATE     = 32'hfff0_000c;
	localparam logic [31:0] ADDR_SECOND_PLL   = 32'hfff0_0010;
	localparam logic [31:0] ADDR_AUDIO_CLK    = 32'hfff0_0014;
	localparam logic [31:0] ADDR_WAKE_CTRL    = 32'hfff0_0020;
	localparam logic [31:0] ADDR_WAKE_FLAGS   = 32'hffff_0024;
	localparam logic [31:0] ADDR_POWER_MODE   = 32'hfff0_0028;
	localparam logic [31:0] ADDR_USB_XCVR     = 32'hfff0_0030;
	// ============================================================
	// Reset values
	localparam logic [31:0] RST_ARB_CTRL      = 32'h0000_0000;
	localparam logic [31:0] RST_SYS_PLL       = 32'h0000_2f01;
	localparam logic [31:0] RST_CLK_GATE      = 32'h1fff_3f08;
	localparam logic [31:0] RST_SECOND_PLL    = 32'h0001_0000;
	localparam logic [31:0] RST_ZERO          = 32'h0000_0000;
	// ============================================================
	// Writable bit masks (reserved bits read zero, but the clock gating reset value sets reserved bit 9)
	localparam logic [31:0] MASK_ARB_CTRL     = 32'h0000_0003;
	localparam logic [31:0] MASK_SYS_PLL      = 32'h0001_ffff;
	localparam logic [31:0] MASK_CLK_GATE     = 32'h1fff_fdff;
	localparam logic [31:0] MASK_SECOND_PLL   = 32'h0001_ffff;
	localparam logic [31:0] MASK_AUDIO_CLK    = 32'h0000_01ff;
	localparam logic [31:0] MASK_WAKE_CTRL    = 32'h0000_00ff;
	localparam logic [31:0] MASK_POWER_MODE   = 32'h0000_0007;
	// ============================================================
	// Field positions
	localparam int ARB_MODE_BIT     = 0;
	localparam int ARB_BOOST_EN_BIT = 1;
	localparam int ARB_BOOST_ACT_BIT = 2;
	localparam int PM_IDLE_BIT      = 0;
	localparam int PM_DEEP_BIT      = 1;
	localparam int PM_MEM_BIT       = 2;
	localparam int PLL_PWDN_BIT     = 16;
	localparam int PLL_FB_MSB       = 15;
	localparam int PLL_FB_LSB       = 7;
	localparam int PLL_OD_MSB       = 6;
	localparam int PLL_OD_LSB       = 5;
	localparam int PLL_IN_MSB       = 4;
	localparam int PLL_IN_LSB       = 0;
	localparam int CLK_SRC_BIT      = 4;
	localparam int PID_PKG_LSB      = 30;
	localparam int PID_VER_LSB      = 24;
	localparam logic [9:0] PLL_DIV_OFFSET = 10'h002;
	// ============================================================
	// Bus masters, index 0 is highest fixed priority, core last
	localparam int NUM_MASTERS      = 9;
	localparam int CORE_MASTER      = 8;
	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS    = 4;
	localparam int OSC_STABLE_NS    = 100000;
	localparam int OSC_STABLE_CYCLES = (OSC_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ============================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ============================================================
	// Power states
	typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_DOWN, PWR_WARM} sbpm_pwr_type;
endpackage
`default_nettype wire

// *** sbpm_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Two-stage synchroniser for pin levels, no reset on the data
// path so a strap held through reset is already settled at release
module sbpm_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input  wire logic             aclk,
	// Asynchronous levels
	input  wire logic [WIDTH-1:0] async_in,
	// Synchronised levels
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;   // First stage, read only by second
	logic [WIDTH-1:0] sync_reg;   // Second stage

	// ============================================================
	// Shift chain
	always_ff @(posedge aclk)
	begin
		meta_reg <= async_in;
		sync_reg <= meta_reg;
	end

	assign sync_out = sync_reg;
endmodule // sbpm_sync
`default_nettype wire

// *** sbpm_arbiter.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Bus arbiter: one owner at a time, fixed or round-robin order
module sbpm_arbiter #(
	parameter int N    = 9,
	parameter int CORE = 8
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Mode controls
	input  wire logic         rotate_mode,
	input  wire logic         core_boost,
	// Master requests and grants
	input  wire logic [N-1:0] bus_req,
	output logic      [N-1:0] bus_grant,
	output logic              bus_busy
);
	localparam int IW = $clog2(N);

	logic [N-1:0]  grant_reg;    // One-hot owner
	logic [N-1:0]  grant_next;
	logic [IW-1:0] last_reg;     // Last owner for rotation
	logic [IW-1:0] last_next;

	// ============================================================
	// First requester at or after a start index, wrapping
	function automatic logic [IW:0] pick_from(input logic [N-1:0] req, input logic [IW-1:0] start);
		logic [IW:0] found;
		logic [IW:0] idx;
		found = {1'b1, {IW{1'b0}}};
		for (int k = N - 1; k >= 0; k--)
		begin
			idx = (IW + 1)'((int'(start) + k) % N);
			if (req[idx[IW-1:0]])
				found = idx;
		end
		return found;
	endfunction

	// ============================================================
	// Next owner selection
	always_comb
	begin
		logic [IW:0] win;
		win = {1'b1, {IW{1'b0}}};
		grant_next = grant_reg;
		last_next = last_reg;
		if ((grant_reg & bus_req) == '0)
		begin
			// Owner released: only now may another request win
			grant_next = '0;
			if (rotate_mode)
				// Round robin, start just after last owner
				win = pick_from(bus_req, (last_reg == IW'(N - 1)) ? '0 : last_reg + 1'b1);
			else if (core_boost && bus_req[CORE])
				// Core lifted above all others
				win = (IW + 1)'(CORE);
			else
				// Lowest index wins, core is last
				win = pick_from(bus_req, '0);
			if (!win[IW])
			begin
				grant_next[win[IW-1:0]] = 1'b1;
				last_next = win[IW-1:0];
			end
		end
	end

	// ============================================================
	// Owner registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			grant_reg <= '0;
			last_reg  <= IW'(N - 1);
		end
		else
		begin
			grant_reg <= grant_next;
			last_reg  <= last_next;
		end
	end

	assign bus_grant = grant_reg;
	assign bus_busy  = |grant_reg;
endmodule // sbpm_arbiter
`default_nettype wire

// *** sbpm_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module sbpm_monitor #(
	parameter int STABLE = sbpm_pkg::OSC_STABLE_CYCLES
) (
	// Clock, reset, handshakes
	input wire logic       aclk, aresetn, awvalid, wvalid, bvalid, irq_req, fiq_req,
	// Clock enables
	input wire logic       core_clk_en, sys_clk_en, osc_en,
	// Arbiter
	input wire logic [8:0] bus_req, bus_grant
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========
	// Arbiter
	property p_one; $onehot0(bus_grant); endproperty
	a_one: assert property (p_one) else $error("two owners");
	property p_keep; (|(bus_grant & bus_req)) |=> $stable(bus_grant); endproperty
	a_keep: assert property (p_keep) else $error("owner lost bus");
	property p_cause; (|bus_grant) |-> |(bus_grant & $past(bus_req)); endproperty
	a_cause: assert property (p_cause) else $error("grant unasked");
	property p_free; (|bus_req) && !(|(bus_grant & bus_req)) |=> |bus_grant; endproperty
	a_free: assert property (p_free) else $error("free bus idle");
	// ==========
	// Write answer one cycle after acceptance
	sequence s_wr; awvalid && wvalid && !bvalid; endsequence
	property p_wr; s_wr |=> bvalid; endproperty
	a_wr: assert property (p_wr) else $error("no write answer");
	// ==========
	// Power; warm-up keeps clocks gated while the oscillator settles
	sequence s_idle; sys_clk_en && !core_clk_en && (irq_req || fiq_req); endsequence
	property p_wake; s_idle |=> core_clk_en; endproperty
	a_wake: assert property (p_wake) else $error("idle not left");
	property p_down; !osc_en |-> !sys_clk_en && !core_clk_en; endproperty
	a_down: assert property (p_down) else $error("clock during sleep");
	// Gated cycles counted, since the settling time is a parameter far above any repetition
	int warm_cycles;
	always_ff @(posedge aclk)
		warm_cycles <= (osc_en && !sys_clk_en) ? warm_cycles + 1 : 0;
	property p_warm; $rose(sys_clk_en) |-> warm_cycles == STABLE; endproperty
	a_warm: assert property (p_warm) else $error("warm-up length");
endmodule // sbpm_monitor
bind sbpm_top sbpm_monitor #(.STABLE(STABLE_CYCLES)) i_mon (.*);
`default_nettype wire

// *** sbpm_masters.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// Nine masters: ask on a start pulse, hold the bus HOLD+3 cycles
module sbpm_masters #(
	parameter int HOLD = 2
) (
	input wire logic       aclk,
	input wire logic [8:0] start,
	input wire logic [8:0] bus_grant,
	output logic     [8:0] bus_req
);
	logic [8:0] last = '0;
	int         cnt  = 0;
	initial bus_req = '0;
	// Request stays up until the owner is done
	always @(posedge aclk)
	begin
		cnt <= (bus_grant != last) ? 0 : cnt + 1;
		last <= bus_grant;
		bus_req <= (bus_req & ~((cnt == HOLD) ? bus_grant : 9'h000)) | start;
	end
endmodule // sbpm_masters
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module testbench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_req, fiq_req, keypad_wake, usb_device_wake;
	logic irq_unmasked_pending, strap_clock_source, strap_endian, awready, wready, bvalid, arready, rvalid, bus_busy;
	logic core_clk_en, cache_clk_en, mem_clk_en, sys_clk_en, osc_en, sys_clk_from_pll, little_endian, pll_power_down;
	logic [31:0] awaddr, wdata, araddr, rdata, periph_clk_en, ld;
	logic [9:0] pll_feedback_value;
	logic [8:0] bus_req, bus_grant, start, gl, q[9];
	logic [5:0] pll_input_value, rdy;
	logic [4:0] en;
	logic [3:0] wstrb, ext_irq_n;
	logic [2:0] awprot, arprot, pll_output_value;
	logic [1:0] bresp, rresp, strap_boot_width, strap_package, boot_width, lr;
	int errors, n_tests, ng;
	// Short warm-up; identity values arbitrary
	sbpm_top #(.STABLE_CYCLES(8), .CHIP_VERSION(6'h15), .PART_CODE(24'h12_3456)) i_dut (.*);
	sbpm_masters i_mst (.*);
	assign en = {core_clk_en, cache_clk_en, mem_clk_en, sys_clk_en, osc_en};
	assign rdy = {en[1], ng == 9, rvalid, arready, bvalid, awready};
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Log each new owner
	always @(posedge aclk)
	begin
		if (bus_grant != gl && bus_grant != 0)
		begin
			q[ng] <= bus_grant;
			ng <= ng + 1;
		end
		gl <= bus_grant;
	end
	task finish_test;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Bounded wait on one ready flag, sampled mid-cycle
	task automatic hs(input int k);
		int n;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (rdy[k] !== 1'b1 && n < 300);
		{ld, lr} = {rdata, k == 1 ? bresp : rresp};
		chk("wait", 1'b1, rdy[k]);
		if (rdy[k] !== 1'b1)
			finish_test();
		@(posedge aclk);
	endtask
	// Register access; d is read expectation
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
		if (w)
			{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
		else
			{araddr, arvalid} <= {a, 1'b1};
		hs(w ? 0 : 2);
		{awvalid, wvalid, arvalid} <= 3'b000;
		hs(w ? 1 : 3);
		chk("resp", e, lr);
		if (!w)
			chk("rdata", d, ld);
	endtask
	task automatic run(input logic [8:0] f, input logic [35:0] e);
		chk("free", 1'b0, bus_busy);
		ng <= 0;
		start <= f;
		@(posedge aclk) start <= ~f;
		@(posedge aclk) start <= '0;
		hs(4);
		chk("busy", 1'b1, bus_busy);
		for (int i = 0; i < 9; i++)
			chk("grant", 9'b1 << e[4*i+:4], q[i]);
	endtask
	task t_regs;
		acc(0, 32'hfff0_0000, 32'h5512_3456, 2'h0);
		acc(0, 32'hfff0_0004, 32'h0000_0000, 2'h0);
		acc(0, 32'hfff0_0008, 32'h0000_2f01, 2'h0);
		acc(0, 32'hfff0_0018, 32'h0000_0000, 2'h3);
		acc(1, 32'hfff0_0008, 32'hffff_ffff, 2'h0);
		acc(0, 32'hfff0_0008, 32'h0001_ffff, 2'h0);
		chk("pll", {1'b1, 10'h201, 6'h21, 3'h4}, {pll_power_down, pll_feedback_value, pll_input_value, pll_output_value});
		chk("straps", 4'b1010, {sys_clk_from_pll, little_endian, boot_width});
		chk("gates", 32'h1fff_3d18, periph_clk_en);
		acc(1, 32'hfff0_000c, 32'h0000_0410, 2'h0);
		chk("gates", 32'h0000_0410, periph_clk_en);
		$display("registers done");
	endtask
	task t_arb;
		irq_unmasked_pending <= 1'b1;
		run(9'h1ff, 36'h8_7654_3210);
		acc(1, 32'hfff0_0004, 32'h0000_0002, 2'h0);
		acc(0, 32'hfff0_0004, 32'h0000_0006, 2'h0);
		run(9'h1ff, 36'h7_6543_2108);
		irq_unmasked_pending <= 1'b0;
		acc(1, 32'hfff0_0004, 32'h0000_0002, 2'h0);
		acc(0, 32'hfff0_0004, 32'h0000_0002, 2'h0);
		acc(1, 32'hfff0_0004, 32'h0000_0006, 2'h0);
		acc(0, 32'hfff0_0004, 32'h0000_0002, 2'h0);
		irq_unmasked_pending <= 1'b1;
		acc(1, 32'hfff0_0004, 32'h0000_0003, 2'h0);
		run(9'h008, 36'h2_1087_6543);
		$display("arbiter done");
	endtask
	task t_pwr;
		acc(1, 32'hfff0_0028, 32'h0000_0005, 2'h0);
		@(negedge aclk) chk("idle", 5'b00011, en);
		@(posedge aclk) irq_req <= 1'b1;
		@(posedge aclk) irq_req <= 1'b0;
		@(negedge aclk) chk("run", 5'h1f, en);
		@(posedge aclk) acc(1, 32'hfff0_0028, 32'h0000_0002, 2'h0);
		@(negedge aclk) chk("sleep", 5'h00, en);
		@(posedge aclk) keypad_wake <= 1'b1;
		hs(5);
		keypad_wake <= 1'b0;
		acc(0, 32'hfff0_0028, 32'h0000_0000, 2'h0);
		// Idle without memory sleep, left by a fast interrupt
		acc(1, 32'hfff0_0028, 32'h0000_0001, 2'h0);
		@(negedge aclk) chk("idle", 5'b00111, en);
		@(posedge aclk) fiq_req <= 1'b1;
		@(posedge aclk) fiq_req <= 1'b0;
		@(negedge aclk) chk("fast", 5'h1f, en);
		// Deep sleep ended by external pin 1, low level
		acc(1, 32'hfff0_0020, 32'h0000_0002, 2'h0);
		acc(1, 32'hfff0_0028, 32'h0000_0002, 2'h0);
		@(posedge aclk) ext_irq_n <= 4'hd;
		hs(5);
		ext_irq_n <= 4'hf;
		acc(0, 32'hffff_0024, 32'h0000_0002, 2'h0);
		$display("power done");
	endtask
	initial
	begin
		{awvalid, wvalid, arvalid, irq_req, fiq_req, irq_unmasked_pending, keypad_wake, usb_device_wake} = '0;
		{awaddr, wdata, araddr, awprot, arprot, start, ng} = '0;
		{bready, rready, wstrb, ext_irq_n} = '1;
		{strap_clock_source, strap_endian, strap_boot_width, strap_package} = 6'b10_1001;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_arb();
		t_pwr();
		finish_test();
	end
endmodule // testbench
`default_nettype wire
